// >>> hdl/spfa_flash_if.v
// Serial interface and write sequencer of the paged flash
`timescale 1ns/1ns
`default_nettype none
`include "spfa_map.vh"

// What this block does
// - Serial output changes after clock falling edge
// - Input bits captured on clock rising edge
// - Deselected: serial output released
// - Standby when deselected and idle
// - Nothing accepted before a select falling edge
// - Reset low and idle: reset mode
// - Running cycle survives reset low
// - Write protect low guards lowest 256 pages
// - Works with clock idling low or high
// - Up to 256 bytes within one page
// - Data stored from low address byte offset
// - Select rising starts the write cycle
// - Fill unreceived bytes, erase (page write only), then program
// - Page program only clears bits
// - Busy flag set during internal cycles
// - Eight sectors of 256 pages of 256 bytes
// - Page erase and sector erase supported
// - Everything shifted most significant bit first
// - Modifying commands need whole byte count
// - Status: bit0 busy, bit1 enable latch
module spfa_flash_if #(
    parameter FIFO_DEPTH = `SPFA_FIFO_DEPTH,
    parameter FIFO_AW    = `SPFA_FIFO_AW
) (
    // Clock and reset
    input  wire                     core_clk,
    input  wire                     rst,
    // Serial bus pins
    input  wire                     spi_sclk,
    input  wire                     spi_cs_n,
    input  wire                     spi_mosi,
    output reg                      spi_miso,
    output reg                      spi_miso_oe,
    // Control pins
    input  wire                     reset_pin_n,
    input  wire                     wp_n,
    // Status
    output wire                     busy_flag,
    output reg                      write_enable_latch,
    output wire                     standby,
    // Flash array port
    output reg                      arr_req,
    output reg  [1:0]               arr_op,
    output reg  [`SPFA_ADDR_W-1:0]  arr_addr,
    output reg  [7:0]               arr_wdata,
    input  wire                     arr_ack,
    input  wire [7:0]               arr_rdata
);
    // Sequencer states, one-hot
    localparam ST_IDLE  = 5'b00001;
    localparam ST_DRAIN = 5'b00010;
    localparam ST_FILL  = 5'b00100;
    localparam ST_ERASE = 5'b01000;
    localparam ST_PROG  = 5'b10000;

    // Pin synchronisers: {sclk, cs_n, mosi, reset_n, wp_n}
    reg  [4:0]  s1_r;                 // First stage, read by s2 only
    reg  [4:0]  s2_r;                 // Second stage
    reg         sclk_d_r;             // Previous synced clock
    reg         cs_d_r;               // Previous synced select
    wire        sclk_s  = s2_r[4];
    wire        cs_s    = s2_r[3];
    wire        mosi_s  = s2_r[2];
    wire        rstn_s  = s2_r[1];
    wire        wpn_s   = s2_r[0];
    wire        sclk_rise = sclk_s & ~sclk_d_r;
    wire        sclk_fall = ~sclk_s & sclk_d_r;
    wire        cs_fall   = ~cs_s & cs_d_r;
    wire        cs_rise   = cs_s & ~cs_d_r;

    // Frame state
    reg         frame_r;              // Inside an accepted frame
    reg  [7:0]  sh_r;                 // Input shift register
    reg  [2:0]  bcnt_r;               // Bit within byte
    reg  [2:0]  nbytes_r;             // Whole bytes, saturates
    reg  [7:0]  opcode_r;             // Instruction byte
    reg  [23:0] addr_r;               // Address bytes
    reg         ovf_r;                // Data lost to a full FIFO
    reg         byte_v_r;             // Data byte ready to push
    reg  [7:0]  byte_r;               // Data byte to push

    // Write sequencer
    reg  [4:0]  state_r;
    reg         is_pw_r;              // Page write in progress
    reg  [`SPFA_PAGE_W-1:0] page_r;   // Target page
    reg  [1:0]  erase_op_r;           // Erase kind
    reg  [7:0]  idx_r;                // Byte walked in the page
    reg  [7:0]  dptr_r;               // Buffer write offset
    reg  [255:0] mask_r;              // Bytes received this frame
    reg         primed_r;             // Buffer read data valid
    reg         pp_mode_r;            // Fill with erased value

    wire        busy   = ~state_r[0];
    wire        in_reset = ~rstn_s & ~busy;
    wire [7:0]  status = {`SPFA_ST_ZERO, write_enable_latch, busy};
    wire [7:0]  nb     = {sh_r[6:0], mosi_s};
    wire        wr_op  = (nb == `SPFA_OP_PW) | (nb == `SPFA_OP_PP);

    // FIFO and buffer wiring
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire        fifo_out_ready = state_r[0] | state_r[1];
    wire [7:0]  fifo_out_data;
    wire        drain    = fifo_out_valid & fifo_out_ready;
    wire        fill_pp  = state_r[2] & ~arr_req & ~mask_r[idx_r] &
                           pp_mode_r;
    wire        fill_got = state_r[2] & arr_req & arr_ack;
    wire        bw_en    = drain | fill_pp | fill_got;
    wire [7:0]  bw_addr  = drain ? dptr_r : idx_r;
    wire [7:0]  bw_data  = drain ? fifo_out_data :
                           (fill_got ? arr_rdata : `SPFA_ERASED);
    wire [7:0]  buf_rd;

    // Lowest sector holds the 256 pages under write protect
    function prot_hit;
        input [23:0] a;
        input        wpn;
        begin
            prot_hit = ~wpn &
                (a[`SPFA_ADDR_W-1:16] == `SPFA_PROT_SECTOR);
        end
    endfunction

    assign busy_flag = busy;
    assign standby   = cs_s & ~busy;

    spfa_fifo #(
        .W      (8),
        .DEPTH  (FIFO_DEPTH),
        .AW     (FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (byte_v_r),
        .in_ready  (fifo_in_ready),
        .in_data   (byte_r),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    spfa_page_buf #(
        .DW (8),
        .AW (8)
    ) u_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (bw_en),
        .wr_addr  (bw_addr),
        .wr_data  (bw_data),
        .rd_addr  (idx_r),
        .rd_data  (buf_rd)
    );

    // Two-flop synchronisers; cs history starts low so a select held
    // low from power-up never looks like a falling edge
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r     <= 5'h00;
            s2_r     <= 5'h00;
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b0;
        end else begin
            s1_r     <= {spi_sclk, spi_cs_n, spi_mosi, reset_pin_n, wp_n};
            s2_r     <= s1_r;
            sclk_d_r <= sclk_s;
            cs_d_r   <= cs_s;
        end
    end

    // Serial receiver, output shifter and command execution
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_r <= 1'b0;
            sh_r <= 8'h00;
            bcnt_r <= 3'h0;
            nbytes_r <= 3'h0;
            opcode_r <= 8'h00;
            addr_r <= 24'h000000;
            ovf_r <= 1'b0;
            byte_v_r <= 1'b0;
            byte_r <= 8'h00;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
            write_enable_latch <= 1'b0;
            state_r <= ST_IDLE;
            is_pw_r <= 1'b0;
            pp_mode_r <= 1'b0;
            page_r <= {`SPFA_PAGE_W{1'b0}};
            erase_op_r <= `SPFA_AOP_EPAGE;
            idx_r <= 8'h00;
            dptr_r <= 8'h00;
            mask_r <= 256'h0;
            primed_r <= 1'b0;
            arr_req <= 1'b0;
            arr_op <= `SPFA_AOP_READ;
            arr_addr <= {`SPFA_ADDR_W{1'b0}};
            arr_wdata <= 8'h00;
        end else begin
            byte_v_r    <= 1'b0;
            // Output driven only while selected and out of reset
            spi_miso_oe <= frame_r & ~cs_s & ~in_reset;
            // Frame opens only on a seen select falling edge
            if (in_reset) begin
                frame_r            <= 1'b0;
                write_enable_latch <= 1'b0;
            end else if (cs_fall) begin
                frame_r  <= 1'b1;
                bcnt_r   <= 3'h0;
                nbytes_r <= 3'h0;
                ovf_r    <= 1'b0;
            end else if (cs_rise) begin
                frame_r <= 1'b0;
            end
            // Rising edge: shift in, MSB first, either clock polarity
            if (frame_r && !cs_s && sclk_rise) begin
                sh_r   <= nb;
                bcnt_r <= bcnt_r + 3'h1;
                if (bcnt_r == 3'h7) begin
                    if (nbytes_r != `SPFA_NB_DATA) begin
                        nbytes_r <= nbytes_r + 3'h1;
                    end
                    if (nbytes_r == 3'h0) begin
                        opcode_r <= nb;
                        if (wr_op && !busy) begin
                            mask_r <= 256'h0;
                        end
                    end else if (nbytes_r < `SPFA_NB_ADDR) begin
                        addr_r <= {addr_r[15:0], nb};
                        if (nbytes_r == 3'h3) begin
                            dptr_r <= nb;
                        end
                    end else if (!busy &&
                                 ((opcode_r == `SPFA_OP_PW) ||
                                  (opcode_r == `SPFA_OP_PP))) begin
                        byte_v_r <= 1'b1;
                        byte_r   <= nb;
                    end
                end
            end
            // A full FIFO drops the byte and spoils the frame
            if (byte_v_r && !fifo_in_ready) begin
                ovf_r <= 1'b1;
            end
            // Falling edge: present next status bit, MSB first
            if (frame_r && !cs_s && sclk_fall &&
                opcode_r == `SPFA_OP_RDSR && nbytes_r != 3'h0) begin
                spi_miso <= status[~bcnt_r];
            end
            // Drain writes land at consecutive offsets in the page
            if (drain) begin
                dptr_r         <= dptr_r + 8'h01;
                mask_r[dptr_r] <= 1'b1;
            end
            // Execute on select rising at a byte boundary only
            if (cs_rise && frame_r && !in_reset && !busy &&
                bcnt_r == 3'h0) begin
                page_r <= addr_r[`SPFA_ADDR_W-1:8];
                idx_r  <= 8'h00;
                case (opcode_r)
                    `SPFA_OP_WRITE_ENABLE_CMD: begin
                        if (nbytes_r == `SPFA_NB_OP) begin
                            write_enable_latch <= 1'b1;
                        end
                    end
                    `SPFA_OP_WRDI: begin
                        if (nbytes_r == `SPFA_NB_OP) begin
                            write_enable_latch <= 1'b0;
                        end
                    end
                    `SPFA_OP_PW, `SPFA_OP_PP: begin
                        if (write_enable_latch && !ovf_r &&
                            nbytes_r == `SPFA_NB_DATA &&
                            !prot_hit(addr_r, wpn_s)) begin
                            state_r   <= ST_DRAIN;
                            is_pw_r   <= (opcode_r == `SPFA_OP_PW);
                            pp_mode_r <= (opcode_r == `SPFA_OP_PP);
                        end
                    end
                    `SPFA_OP_PE, `SPFA_OP_SE: begin
                        if (write_enable_latch &&
                            nbytes_r == `SPFA_NB_ADDR &&
                            !prot_hit(addr_r, wpn_s)) begin
                            state_r    <= ST_ERASE;
                            is_pw_r    <= 1'b0;
                            erase_op_r <= (opcode_r == `SPFA_OP_PE) ?
                                `SPFA_AOP_EPAGE : `SPFA_AOP_ESECT;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Internal cycle; the reset pin is not consulted here
            case (state_r)
                ST_IDLE: begin
                end
                ST_DRAIN: begin
                    // Wait until every received byte sits in the buffer
                    if (!fifo_out_valid) begin
                        state_r    <= ST_FILL;
                        erase_op_r <= `SPFA_AOP_EPAGE;
                    end
                end
                ST_FILL: begin
                    // Unreceived bytes: old page data, or erased value
                    if (!arr_req && mask_r[idx_r]) begin
                        idx_r <= idx_r + 8'h01;
                    end else if (fill_pp) begin
                        idx_r <= idx_r + 8'h01;
                    end else if (!arr_req) begin
                        arr_req  <= 1'b1;
                        arr_op   <= `SPFA_AOP_READ;
                        arr_addr <= {page_r, idx_r};
                    end else if (arr_ack) begin
                        arr_req <= 1'b0;
                        idx_r   <= idx_r + 8'h01;
                    end
                    if (idx_r == `SPFA_LAST_BYTE &&
                        ((!arr_req && (mask_r[idx_r] || pp_mode_r)) ||
                         (arr_req && arr_ack))) begin
                        // Page program skips the erase step
                        state_r <= is_pw_r ? ST_ERASE : ST_PROG;
                    end
                end
                ST_ERASE: begin
                    if (!arr_req) begin
                        arr_req  <= 1'b1;
                        arr_op   <= erase_op_r;
                        arr_addr <= {page_r, 8'h00};
                    end else if (arr_ack) begin
                        arr_req <= 1'b0;
                        idx_r   <= 8'h00;
                        if (is_pw_r) begin
                            state_r <= ST_PROG;
                        end else begin
                            state_r            <= ST_IDLE;
                            write_enable_latch <= 1'b0;
                        end
                    end
                end
                ST_PROG: begin
                    // Buffer read takes a cycle before the request
                    if (!arr_req && !primed_r) begin
                        primed_r <= 1'b1;
                    end else if (!arr_req) begin
                        arr_req   <= 1'b1;
                        arr_op    <= `SPFA_AOP_PROG;
                        arr_addr  <= {page_r, idx_r};
                        arr_wdata <= buf_rd;
                    end else if (arr_ack) begin
                        arr_req  <= 1'b0;
                        primed_r <= 1'b0;
                        idx_r    <= idx_r + 8'h01;
                        if (idx_r == `SPFA_LAST_BYTE) begin
                            state_r            <= ST_IDLE;
                            write_enable_latch <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // spfa_flash_if
`default_nettype wire

// >>> hdl/spfa_map.vh
// Constants of the paged serial flash access block
`ifndef SPFA_MAP_VH
`define SPFA_MAP_VH
// Instruction codes
`define SPFA_OP_WRITE_ENABLE_CMD     8'h06
`define SPFA_OP_WRDI     8'h04
`define SPFA_OP_RDSR     8'h05
`define SPFA_OP_PW       8'h0A
`define SPFA_OP_PP       8'h02
`define SPFA_OP_PE       8'hDB
`define SPFA_OP_SE       8'hD8
// Status byte fields
`define SPFA_ST_BUSY     0
`define SPFA_ST_WEL      1
`define SPFA_ST_ZERO     6'h00
// Array operations
`define SPFA_AOP_READ    2'h0
`define SPFA_AOP_PROG    2'h1
`define SPFA_AOP_EPAGE   2'h2
`define SPFA_AOP_ESECT   2'h3
// Array geometry: 8 sectors x 256 pages x 256 bytes
`define SPFA_ADDR_W      19
`define SPFA_PAGE_W      11
`define SPFA_PROT_SECTOR 3'h0
`define SPFA_ERASED      8'hFF
`define SPFA_LAST_BYTE   8'hFF
// Byte counts within a frame
`define SPFA_NB_OP       3'h1
`define SPFA_NB_ADDR     3'h4
`define SPFA_NB_DATA     3'h5
// Data FIFO size
`define SPFA_FIFO_DEPTH  16
`define SPFA_FIFO_AW     4
`endif

// >>> hdl/spfa_fifo.v
// Byte FIFO between the serial receiver and the page buffer
`timescale 1ns/1ns
`default_nettype none
module spfa_fifo #(
    parameter W     = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst,
    // Filling side
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    // Draining side
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);
    reg  [W-1:0] mem_r [0:DEPTH-1];  // Storage
    reg  [AW-1:0] wp_r;              // Write pointer
    reg  [AW-1:0] rp_r;              // Read pointer
    reg  [AW:0]   cnt_r;             // Fill level
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage has no reset; only pointers and fill level need a defined value
    always @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // Pointers wrap, so depth must be a power of two
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // spfa_fifo
`default_nettype wire

// >>> hdl/spfa_page_buf.v
// Page buffer memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module spfa_page_buf #(
    parameter DW = 8,
    parameter AW = 8
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read port, data one cycle after the address
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];  // Buffer bytes

    // Write side
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // Registered read
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= {DW{1'b0}};
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule // spfa_page_buf
`default_nettype wire

// >>> verification/spfa_chk_sva.sv
// Port checker of the paged flash access block
`timescale 1ns/1ns
`default_nettype none
module spfa_chk (
    // Clock, reset and pins
    input wire       core_clk, rst, spi_sclk, spi_cs_n,
    input wire       spi_miso, spi_miso_oe, reset_pin_n, wp_n,
    // Status and array port
    input wire       busy_flag, write_enable_latch, standby,
    input wire       arr_req, arr_ack,
    input wire [1:0] arr_op,
    input wire [18:0] arr_addr,
    input wire [7:0] arr_wdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    reg [7:0] wp_lo_r; // Cycles write protect held low, saturating
    // Synchroniser delay kept out of the guard check
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            wp_lo_r <= 8'h00;
        else
            wp_lo_r <= wp_n ? 8'h00 : wp_lo_r + {7'h00, wp_lo_r != 8'hFF};
    end
    sequence rst_idle_s; (!reset_pin_n && !busy_flag) [*5]; endsequence
    sequence req_open_s; arr_req && !arr_ack; endsequence
    deselect_release_a: assert property (
        spi_cs_n [*5] |-> !spi_miso_oe) else $error("oe high");
    idle_standby_a: assert property (
        standby |-> !busy_flag && $past(spi_cs_n, 2)) else $error("standby");
    select_active_a: assert property (
        !spi_cs_n [*5] |-> !standby) else $error("standby on");
    reset_mode_a: assert property (
        rst_idle_s |-> !spi_miso_oe && !write_enable_latch)
        else $error("reset mode");
    busy_req_a: assert property (
        arr_req |-> busy_flag) else $error("idle req");
    req_hold_a: assert property (
        req_open_s |=> arr_req && $stable(arr_op) && $stable(arr_addr)
        && $stable(arr_wdata)) else $error("req moved");
    req_drop_a: assert property (
        arr_req && arr_ack |=> !arr_req) else $error("req kept");
    protect_guard_a: assert property (
        arr_req && arr_op != 2'h0 && wp_lo_r == 8'hFF |-> arr_addr[18:16] != 3'h0)
        else $error("guard");
    miso_timing_a: assert property (
        $changed(spi_miso) && spi_miso_oe && $past(spi_miso_oe) |-> !spi_sclk)
        else $error("miso early");
    cycle_start_a: assert property (
        $rose(busy_flag) |-> spi_cs_n && $past(spi_cs_n, 2))
        else $error("early start");
    end_latch_a: assert property (
        $fell(busy_flag) |-> !write_enable_latch) else $error("latch kept");
endmodule // spfa_chk
bind spfa_flash_if spfa_chk CHK (.*);
`default_nettype wire

// >>> verification/spfa_arr_model.sv
// Behavioural flash array answering the block's array port
`timescale 1ns/1ns
`default_nettype none
module spfa_arr_model (
    // Clock and reset
    input wire        core_clk, rst,
    // Request side
    input wire        arr_req, slow,
    input wire [1:0]  arr_op,
    input wire [18:0] arr_addr,
    input wire [7:0]  arr_wdata,
    // Answer side
    output reg        arr_ack,
    output reg [7:0]  arr_rdata
);
    logic [7:0] mem [bit [18:0]]; // Sparse array, absent bytes are erased
    reg [2:0]   wait_r;           // Wait cycles spent on the open request
    function automatic logic [7:0] rd(input bit [18:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    // One request at a time; ack is a one-cycle pulse
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            arr_ack <= 1'b0;
            arr_rdata <= 8'h00;
            wait_r <= 3'h0;
        end else begin
            arr_ack <= 1'b0;
            arr_rdata <= ~arr_rdata; // Garbage unless ack says valid
            if (arr_req && !arr_ack && wait_r < (slow ? 3'h5 : 3'h0))
                wait_r <= wait_r + 3'h1;
            else if (arr_req && !arr_ack) begin
                arr_ack <= 1'b1;
                wait_r <= 3'h0;
                case (arr_op)
                    2'h0: arr_rdata <= rd(arr_addr);
                    2'h1: mem[arr_addr] = rd(arr_addr) & arr_wdata;
                    2'h2: for (int i = 0; i < 256; i++)
                        mem.delete({arr_addr[18:8], i[7:0]});
                    default: for (int i = 0; i < 65536; i++)
                        mem.delete({arr_addr[18:16], i[15:0]});
                endcase
            end
        end
    end
endmodule // spfa_arr_model
`default_nettype wire

// >>> verification/spfa_flash_if_bench.sv
// Self-checking bench of the paged flash access block
`timescale 1ns/1ns
`default_nettype none
module spfa_flash_if_bench;
    localparam int H = 6; // Half serial clock period
    reg core_clk, rst, spi_sclk, spi_cs_n, spi_mosi, reset_pin_n, wp_n;
    reg slow, cpol;       // Array wait states, serial clock idle level
    reg [7:0] st;         // Last byte read in a frame
    wire spi_miso, spi_miso_oe, busy_flag, write_enable_latch, standby;
    wire arr_req, arr_ack;
    wire [1:0] arr_op;
    wire [18:0] arr_addr;
    wire [7:0] arr_wdata, arr_rdata;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    spfa_flash_if DUT (.*);
    spfa_arr_model ARR (.*);
    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask
    // Bits go out MSB first; the reply is sampled just before each rise
    task automatic xfer(input [7:0] b, output [7:0] r, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            spi_sclk <= 1'b0;
            spi_mosi <= b[i];
            tick(H);
            r[i] = spi_miso;
            spi_sclk <= 1'b1;
            tick(H);
        end
    endtask
    // One frame; extra adds a partial byte
    task automatic frame(input logic [7:0] q[$], input int extra = 0);
        logic [7:0] r;
        spi_sclk <= cpol;
        tick(2);
        spi_cs_n <= 1'b0;
        tick(H);
        foreach (q[k]) xfer(q[k], r, 8);
        st = r;
        if (extra > 0) xfer(8'h00, r, extra);
        spi_sclk <= cpol;
        tick(H);
        spi_cs_n <= 1'b1;
        tick(2 * H);
    endtask
    // Polls status until busy clears
    task automatic wait_idle;
        for (int n = 0; n < 300; n++) begin
            frame('{8'h05, 8'h00});
            if (st[0] === 1'b0) return;
        end
        chk("idle wait", 0, 1);
    endtask
    // Select low since power-up: a full opcode must be ignored
    task automatic t_power_up;
        logic [7:0] r;
        xfer(8'h06, r, 8);
        spi_sclk <= 1'b0;
        tick(H);
        spi_cs_n <= 1'b1;
        tick(2 * H);
        chk("latch", 0, write_enable_latch);
        chk("oe", 0, spi_miso_oe);
        chk("standby", 1, standby);
    endtask
    // Enable needs a whole byte; status shows the latch
    task automatic t_enable;
        frame('{8'h06}, 1);
        chk("latch", 0, write_enable_latch);
        frame('{8'h06});
        frame('{8'h05, 8'h00});
        chk("status", 8'h02, st);
        frame('{8'h04});
        chk("latch", 0, write_enable_latch);
    endtask
    // Page write wrapping at the page end keeps unsent bytes
    task automatic t_write;
        ARR.mem[19'h12310] = 8'h77;
        frame('{8'h06});
        frame('{8'h0A, 8'h01, 8'h23, 8'hFE, 8'hA5, 8'h5A, 8'hC3});
        chk("busy", 1, busy_flag);
        wait_idle();
        chk("b0", 8'hA5, ARR.rd(19'h123FE));
        chk("b1", 8'h5A, ARR.rd(19'h123FF));
        chk("b2", 8'hC3, ARR.rd(19'h12300));
        chk("kept", 8'h77, ARR.rd(19'h12310));
        chk("latch", 0, write_enable_latch);
    endtask
    // Page program with clock idling high only clears bits
    task automatic t_program;
        cpol = 1'b1;
        frame('{8'h06});
        frame('{8'h02, 8'h01, 8'h23, 8'h10, 8'h0F});
        wait_idle();
        chk("and", 8'h07, ARR.rd(19'h12310));
        chk("no erase", 8'hA5, ARR.rd(19'h123FE));
        cpol = 1'b0;
    endtask
    // Last protected page refused, then page and sector erase
    task automatic t_protect;
        ARR.mem[19'h0FF00] = 8'h12;
        wp_n <= 1'b0;
        tick(300);
        frame('{8'h06});
        frame('{8'hDB, 8'h00, 8'hFF, 8'h00});
        tick(50);
        chk("guard", 8'h12, ARR.rd(19'h0FF00));
        chk("latch", 1, write_enable_latch);
        wp_n <= 1'b1;
        tick(4);
        frame('{8'hDB, 8'h00, 8'hFF, 8'h00});
        wait_idle();
        chk("page erase", 8'hFF, ARR.rd(19'h0FF00));
        frame('{8'h06});
        frame('{8'hD8, 8'h01, 8'h00, 8'h00});
        wait_idle();
        chk("sector erase", 8'hFF, ARR.rd(19'h12310));
    endtask
    // Reset pin low mid-cycle must not stop the write
    task automatic t_reset_busy;
        slow <= 1'b1;
        frame('{8'h06});
        frame('{8'h0A, 8'h02, 8'h00, 8'h10, 8'h3C});
        reset_pin_n <= 1'b0;
        tick(4);
        chk("busy", 1, busy_flag);
        for (int n = 0; n < 20000 && busy_flag !== 1'b0; n++) tick(1);
        tick(5);
        chk("done", 8'h3C, ARR.rd(19'h20010));
        chk("oe", 0, spi_miso_oe);
        chk("latch", 0, write_enable_latch);
        reset_pin_n <= 1'b1;
        slow <= 1'b0;
    endtask
    task automatic summarize;
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1; spi_sclk = 1'b0; spi_cs_n = 1'b0; spi_mosi = 1'b0;
        reset_pin_n = 1'b0; wp_n = 1'b1; slow = 1'b0; cpol = 1'b0;
        tick(10);
        rst <= 1'b0;
        reset_pin_n <= 1'b1;
        tick(4);
        t_power_up();
        t_enable();
        t_write();
        t_program();
        t_protect();
        t_reset_busy();
        summarize();
    end
endmodule // spfa_flash_if_bench
`default_nettype wire
